// *** diag_defs.svh ***
// Constants of the diagnostic error monitor
`ifndef DIAG_DEFS_SVH
`define DIAG_DEFS_SVH
`define DIAG_CLK_NS         10
`define DIAG_LOAD_DELAY_NS  1000
`define DIAG_MCLK_DIV       131
`define DIAG_MOD_RUN        20
`define DIAG_OFFSET_MIN     16'h07FF
`define DIAG_OFFSET_MAX     16'hF7FF
`define DIAG_CMD_BITS       8
`define DIAG_MIN_WRITE_BITS 16
`define DIAG_READ_BIT       7
`define DIAG_NUM_REGS       64
`endif

// *** diag_pkg.sv ***
// Types shared by the diagnostic error monitor
package diag_pkg;
    // One bit per error source; used for flags, enables and clear masks
    typedef struct packed {
        logic refMissing;
        logic conversion;
        logic posInput;
        logic negInput;
        logic refRange;
        logic sclkCount;
        logic readErr;
        logic writeErr;
        logic ignoredWrite;
    } diag_bits_t;

    // Raw comparator levels from the analog front end
    typedef struct packed {
        logic refBelow;
        logic refOpen;
        logic posOver;
        logic posUnder;
        logic negOver;
        logic negUnder;
        logic refPosOver;
        logic refNegUnder;
    } analog_cmp_t;

    // Accepted register write handed to the register file
    typedef struct packed {
        logic        valid;
        logic [6:0]  addr;
        logic [23:0] data;
    } reg_write_t;
endpackage

// *** adc_diagnostic_error_monitor.sv ***
// Diagnostic error monitor: analog, conversion, clock and serial checks
//
// Functional notes
// - Enabled reference-missing detection sets its flag; main error follows.
// - Filter overflow/underflow sets conversion flag and clamps result to ones/zeros.
// - Twenty identical modulator bits in a row set the conversion flag.
// - Offset coefficient outside range: keep old coefficient, set conversion flag.
// - Filter overflow in gain calibration: keep gain coefficient, set flag.
// - Conversion flag refreshed with each result; cleared only by writing one.
// - Each analog input has its own range enable and flag.
// - One reference range flag for either reference pin out of supply.
// - Range flags set only while enabled; write one clears them.
// - Main-clock count steps every 131 cycles while enabled, wrapping.
// - Frame clock count not a multiple of eight, or over 63, sets the clock-count flag.
// - Write with too few clocks is aborted when the check is on.
// - Checked read of an unmapped address sets read flag, returns zeros.
// - Checked write to read-only or unmapped address sets flag, is aborted.
// - Registers inaccessible during default load, calibration, single-sequence run.
// - Ignored-access flag shows unwritable registers; its check can be disabled.
// - Writes while the ignored-access flag is set are dropped; write one clears.
`timescale 1ns/100ps
`include "diag_defs.svh"

module adc_diagnostic_error_monitor #(
    parameter int            RESULT_WIDTH   = 16,
    parameter int            COUNT_WIDTH    = 8,
    parameter int            MIN_WRITE_BITS = `DIAG_MIN_WRITE_BITS,
    parameter logic [127:0]  READ_ONLY_MASK = 128'h0
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        serialClk,
    input  wire logic                        chipSelectN,
    input  wire logic                        serialDataIn,
    input  wire diag_pkg::analog_cmp_t       analogCmp,
    input  wire diag_pkg::diag_bits_t        checkEnable,
    input  wire logic                        mainClockCounterEnable,
    input  wire logic                        errClear,
    input  wire diag_pkg::diag_bits_t        errClearMask,
    input  wire logic                        filterOverflow,
    input  wire logic                        filterUnderflow,
    input  wire logic                        modBitValid,
    input  wire logic                        modBit,
    input  wire logic                        resultValid,
    input  wire logic [RESULT_WIDTH-1:0]     rawResult,
    input  wire logic                        calBusy,
    input  wire logic                        calIsGain,
    input  wire logic                        calDone,
    input  wire logic [15:0]                 calOffset,
    input  wire logic                        singleSeqBusy,
    output diag_pkg::diag_bits_t             errorFlags,
    output logic                             mainError,
    output logic [RESULT_WIDTH-1:0]          convResult,
    output logic                             resultUpdate,
    output logic                             offsetLoad,
    output logic                             gainLoad,
    output logic [COUNT_WIDTH-1:0]           mclkCount,
    output diag_pkg::reg_write_t             regWrite,
    output logic                             readBlank,
    output logic                             accessBlocked
);
    import diag_pkg::*;

    localparam int          LOAD_CYCLES = (`DIAG_LOAD_DELAY_NS + `DIAG_CLK_NS - 1) / `DIAG_CLK_NS;
    localparam logic [7:0]  DIV_LAST    = 8'(`DIAG_MCLK_DIV - 1);
    localparam logic [4:0]  RUN_LAST    = 5'(`DIAG_MOD_RUN - 1);
    localparam logic [5:0]  CMD_LAST    = 6'(`DIAG_CMD_BITS - 1);
    localparam logic [5:0]  CMD_FULL    = 6'(`DIAG_CMD_BITS);
    localparam logic [5:0]  WRITE_MIN   = 6'(MIN_WRITE_BITS);

    function automatic logic addrMapped(input logic [6:0] a);
        addrMapped = (a < 7'(`DIAG_NUM_REGS));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock domain: counts clocks and captures command and data

    logic        frameFresh_reg;
    logic        frameToggle_reg;
    logic [5:0]  bitCount_reg;
    logic [23:0] shiftIn_reg;
    logic [7:0]  cmd_reg;
    logic [1:0]  readChkSync_reg;
    logic        readBlank_reg;

    // Select high re-arms the frame; the serial clock is still outside frames
    always_ff @(posedge serialClk or posedge rst or posedge chipSelectN) begin
        if (rst || chipSelectN) begin
            frameFresh_reg <= 1'b1;
        end else begin
            frameFresh_reg <= 1'b0;
        end
    end

    always_ff @(posedge serialClk or posedge rst) begin
        if (rst) begin
            bitCount_reg    <= 6'h00;
            shiftIn_reg     <= 24'h000000;
            cmd_reg         <= 8'h00;
            frameToggle_reg <= 1'b0;
        end else if (frameFresh_reg) begin
            bitCount_reg    <= 6'h01;
            shiftIn_reg     <= {23'h000000, serialDataIn};
            // Flips once per clocked frame so a bare select pulse repeats nothing
            frameToggle_reg <= ~frameToggle_reg;
        end else begin
            if (bitCount_reg != 6'h3F) begin
                bitCount_reg <= bitCount_reg + 6'h01;
            end
            shiftIn_reg <= {shiftIn_reg[22:0], serialDataIn};
            if (bitCount_reg == CMD_LAST) begin
                cmd_reg <= {shiftIn_reg[6:0], serialDataIn};
            end
        end
    end

    always_ff @(posedge serialClk or posedge rst) begin
        if (rst) begin
            readChkSync_reg <= 2'b00;
        end else begin
            readChkSync_reg <= {readChkSync_reg[0], checkEnable.readErr};
        end
    end

    // Decided as the command completes so data can be blanked from bit nine on
    always_ff @(posedge serialClk or posedge rst) begin
        if (rst) begin
            readBlank_reg <= 1'b0;
        end else if (frameFresh_reg) begin
            readBlank_reg <= 1'b0;
        end else if (bitCount_reg == CMD_LAST) begin
            readBlank_reg <= shiftIn_reg[`DIAG_READ_BIT-1] && readChkSync_reg[1]
                             && !addrMapped({shiftIn_reg[5:0], serialDataIn});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: frame end, synchronised comparators, access gating

    logic [1:0]    csSync_reg;
    logic          csLast_reg;
    analog_cmp_t   anaSync1_reg;
    analog_cmp_t   anaSync2_reg;
    logic [7:0]    loadCount_reg;
    logic          accessBlocked_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            csSync_reg <= 2'b11;
            csLast_reg <= 1'b1;
        end else begin
            csSync_reg <= {csSync_reg[0], chipSelectN};
            csLast_reg <= csSync_reg[1];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            anaSync1_reg <= '0;
            anaSync2_reg <= '0;
        end else begin
            anaSync1_reg <= analogCmp;
            anaSync2_reg <= anaSync1_reg;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            loadCount_reg     <= 8'(LOAD_CYCLES);
            accessBlocked_reg <= 1'b1;
        end else begin
            if (loadCount_reg != 8'h00) begin
                loadCount_reg <= loadCount_reg - 8'h01;
            end
            accessBlocked_reg <= (loadCount_reg > 8'h01) || calBusy || singleSeqBusy;
        end
    end

    // Serial-domain values are quiet here: the clock stopped before select rose
    logic       frameEnd;
    logic       clocked;
    logic       seenToggle_reg;
    logic       cmdSeen;
    logic       isRead;
    logic [6:0] cmdAddr;
    logic       countBad;
    logic       shortWrite;
    logic       badWrite;
    logic       writeGo;
    diag_bits_t flags_reg;

    assign frameEnd   = csSync_reg[1] && !csLast_reg;
    assign clocked    = frameToggle_reg != seenToggle_reg;
    assign cmdSeen    = clocked && (bitCount_reg >= CMD_FULL);
    assign isRead     = cmd_reg[`DIAG_READ_BIT];
    assign cmdAddr    = cmd_reg[6:0];
    assign countBad   = clocked && (bitCount_reg[2:0] != 3'h0);
    assign shortWrite = bitCount_reg < WRITE_MIN;
    assign badWrite   = !addrMapped(cmdAddr) || READ_ONLY_MASK[cmdAddr];
    assign writeGo    = frameEnd && cmdSeen && !isRead
                        && !(checkEnable.sclkCount && shortWrite)
                        && !(checkEnable.writeErr && badWrite)
                        && !accessBlocked_reg && !flags_reg.ignoredWrite;

    reg_write_t regWrite_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            regWrite_reg <= '0;
        end else begin
            regWrite_reg.valid <= writeGo;
            // Taken only at frame end, while the serial side is quiet
            if (frameEnd) begin
                regWrite_reg.addr <= cmdAddr;
                regWrite_reg.data <= shiftIn_reg;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seenToggle_reg <= 1'b0;
        end else if (frameEnd) begin
            seenToggle_reg <= frameToggle_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion and calibration checks

    logic [4:0]              runLen_reg;
    logic                    lastBit_reg;
    logic                    pendOv_reg;
    logic                    pendUn_reg;
    logic                    pendSat_reg;
    logic                    gainOv_reg;
    logic                    satEvent;
    logic                    ovNow;
    logic                    unNow;
    logic                    offsetBad;
    logic                    calErr;
    logic [RESULT_WIDTH-1:0] convResult_reg;
    logic                    resultUpdate_reg;
    logic                    offsetLoad_reg;
    logic                    gainLoad_reg;

    assign satEvent  = modBitValid && (modBit == lastBit_reg) && (runLen_reg == RUN_LAST);
    assign ovNow     = checkEnable.conversion && !calBusy && filterOverflow;
    assign unNow     = checkEnable.conversion && !calBusy && filterUnderflow;
    assign offsetBad = (calOffset < `DIAG_OFFSET_MIN) || (calOffset > `DIAG_OFFSET_MAX);
    assign calErr    = calIsGain ? (gainOv_reg || filterOverflow) : offsetBad;

    // Run length saturates so one long run gives one event
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            runLen_reg  <= 5'h00;
            lastBit_reg <= 1'b0;
        end else if (modBitValid) begin
            lastBit_reg <= modBit;
            if (modBit != lastBit_reg) begin
                runLen_reg <= 5'h01;
            end else if (runLen_reg <= RUN_LAST) begin
                runLen_reg <= runLen_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pendOv_reg  <= 1'b0;
            pendUn_reg  <= 1'b0;
            pendSat_reg <= 1'b0;
        end else if (resultValid) begin
            pendOv_reg  <= 1'b0;
            pendUn_reg  <= 1'b0;
            pendSat_reg <= 1'b0;
        end else begin
            pendOv_reg  <= pendOv_reg || ovNow;
            pendUn_reg  <= pendUn_reg || unNow;
            pendSat_reg <= pendSat_reg || (satEvent && checkEnable.conversion);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            convResult_reg   <= '0;
            resultUpdate_reg <= 1'b0;
        end else begin
            resultUpdate_reg <= resultValid;
            if (resultValid) begin
                if (pendOv_reg || ovNow) begin
                    convResult_reg <= '1;
                end else if (pendUn_reg || unNow) begin
                    convResult_reg <= '0;
                end else begin
                    convResult_reg <= rawResult;
                end
            end
        end
    end

    // Coefficient loads are withheld on error even with the check disabled
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gainOv_reg     <= 1'b0;
            offsetLoad_reg <= 1'b0;
            gainLoad_reg   <= 1'b0;
        end else begin
            gainOv_reg     <= calDone ? 1'b0 : (gainOv_reg || (calBusy && filterOverflow));
            offsetLoad_reg <= calDone && !calIsGain && !offsetBad;
            gainLoad_reg   <= calDone && calIsGain && !calErr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main clock counter

    logic [7:0]             prescale_reg;
    logic [COUNT_WIDTH-1:0] mclkCount_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prescale_reg  <= 8'h00;
            mclkCount_reg <= '0;
        end else if (!mainClockCounterEnable) begin
            prescale_reg <= 8'h00;
        end else if (prescale_reg == DIV_LAST) begin
            prescale_reg  <= 8'h00;
            mclkCount_reg <= mclkCount_reg + 1'b1;
        end else begin
            prescale_reg <= prescale_reg + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags and main error

    diag_bits_t setBits;
    diag_bits_t clrBits;
    logic       mainError_reg;

    always_comb begin
        setBits              = '0;
        setBits.refMissing   = checkEnable.refMissing && (anaSync2_reg.refBelow || anaSync2_reg.refOpen);
        setBits.conversion   = checkEnable.conversion
                               && ((resultValid && (pendOv_reg || pendUn_reg || pendSat_reg
                                    || ovNow || unNow || satEvent))
                                   || (calDone && calErr));
        setBits.posInput     = checkEnable.posInput && (anaSync2_reg.posOver || anaSync2_reg.posUnder);
        setBits.negInput     = checkEnable.negInput && (anaSync2_reg.negOver || anaSync2_reg.negUnder);
        setBits.refRange     = checkEnable.refRange
                               && (anaSync2_reg.refPosOver || anaSync2_reg.refNegUnder);
        setBits.sclkCount    = checkEnable.sclkCount && frameEnd && countBad;
        setBits.readErr      = checkEnable.readErr && frameEnd && cmdSeen && isRead
                               && !addrMapped(cmdAddr);
        setBits.writeErr     = checkEnable.writeErr && frameEnd && cmdSeen && !isRead && badWrite;
        setBits.ignoredWrite = checkEnable.ignoredWrite && frameEnd && cmdSeen && !isRead
                               && accessBlocked_reg;
        clrBits              = errClear ? errClearMask : '0;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= diag_bits_t'((flags_reg & ~clrBits) | setBits);
        end
    end

    // One cycle behind the flags it summarises
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mainError_reg <= 1'b0;
        end else begin
            mainError_reg <= |(flags_reg & checkEnable);
        end
    end

    assign errorFlags    = flags_reg;
    assign mainError     = mainError_reg;
    assign convResult    = convResult_reg;
    assign resultUpdate  = resultUpdate_reg;
    assign offsetLoad    = offsetLoad_reg;
    assign gainLoad      = gainLoad_reg;
    assign mclkCount     = mclkCount_reg;
    assign regWrite      = regWrite_reg;
    assign readBlank     = readBlank_reg;
    assign accessBlocked = accessBlocked_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_clamp_high: assert property (resultValid && (pendOv_reg || ovNow) |=> convResult == '1)
        else $error("overflowed result not clamped high");
    a_mod_run: assert property (satEvent && checkEnable.conversion && !resultValid |=> pendSat_reg)
        else $error("modulator run not recorded");
    a_offset_keep: assert property (calDone && !calIsGain && offsetBad && checkEnable.conversion
        |=> !offsetLoad && errorFlags.conversion)
        else $error("bad offset loaded or not flagged");
    a_gain_keep: assert property (calDone && calIsGain && gainOv_reg |=> !gainLoad)
        else $error("gain loaded after overflow");
    a_flag_hold: assert property (errorFlags.conversion && !(errClear && errClearMask.conversion)
        |=> errorFlags.conversion)
        else $error("conversion flag dropped without clear");
    a_input_gate: assert property (!checkEnable.posInput && !errorFlags.posInput |=> !errorFlags.posInput)
        else $error("input flag set while disabled");
    a_mclk_step: assert property (mainClockCounterEnable && prescale_reg == DIV_LAST
        |=> mclkCount == $past(mclkCount) + 1'b1)
        else $error("main clock count did not step");
    a_sclk_flag: assert property (frameEnd && countBad && checkEnable.sclkCount |=> errorFlags.sclkCount)
        else $error("odd clock count not flagged");
    a_short_abort: assert property (frameEnd && shortWrite && checkEnable.sclkCount |=> !regWrite.valid)
        else $error("short write committed");
    a_ignore_drop: assert property (frameEnd && (accessBlocked_reg || errorFlags.ignoredWrite)
        |=> !regWrite.valid ##1 !regWrite.valid)
        else $error("write accepted while blocked");
    a_main_or: assert property (##1 mainError == |($past(errorFlags) & $past(checkEnable)))
        else $error("main error mismatch");

    c_clamp: cover property (resultValid && ovNow);
    c_sat: cover property (satEvent);
    c_write: cover property (writeGo);
    c_ignored: cover property (setBits.ignoredWrite);
endmodule

// *** spi_host_model.sv ***
// Serial host model that frames commands and data on the link
`timescale 1ns/100ps
module spi_host_model #(
    parameter int HALF_NS = 80
) (
    output logic serialClk,
    output logic chipSelectN,
    output logic serialDataIn
);
    initial begin
        serialClk = 1'b0;
        chipSelectN = 1'b1;
        serialDataIn = 1'b0;
    end
    // Clock stands still outside frames; select brackets every transfer
    task automatic frame(input int nBits, input logic [31:0] word);
        #3.3;
        chipSelectN = 1'b0;
        #(HALF_NS);
        for (int i = nBits - 1; i >= 0; i--) begin
            serialDataIn = word[i];
            #(HALF_NS);
            serialClk = 1'b1;
            #(HALF_NS);
            serialClk = 1'b0;
        end
        #(HALF_NS);
        chipSelectN = 1'b1;
        // Released line shows the inverse so no stale bit looks valid
        serialDataIn = ~serialDataIn;
        #(HALF_NS * 2);
    endtask
endmodule

// *** adc_diagnostic_error_monitor_tb.sv ***
// Self-checking bench of the diagnostic error monitor
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module adc_diagnostic_error_monitor_tb;
    import diag_pkg::*;
    logic        core_clk, rst, serialClk, chipSelectN, serialDataIn, mainClockCounterEnable, errClear;
    logic        filterOverflow, filterUnderflow, modBitValid, modBit, resultValid, calBusy, calIsGain, calDone;
    logic        singleSeqBusy, mainError, resultUpdate, offsetLoad, gainLoad, readBlank, accessBlocked;
    logic [15:0] rawResult, calOffset, convResult;
    logic [7:0]  mclkCount;
    logic [31:0] rnd;
    analog_cmp_t analogCmp;
    diag_bits_t  checkEnable, errClearMask, errorFlags;
    reg_write_t  regWrite, wantWr;
    reg_write_t  expWr[$];
    int          miscompares = 0, n_tests = 0, seed = 63;
    spi_host_model host_u (.serialClk(serialClk), .chipSelectN(chipSelectN), .serialDataIn(serialDataIn));
    adc_diagnostic_error_monitor #(.READ_ONLY_MASK(128'h1 << 63)) dut_u (.core_clk(core_clk), .rst(rst),
        .serialClk(serialClk),
        .chipSelectN(chipSelectN), .serialDataIn(serialDataIn), .analogCmp(analogCmp), .checkEnable(checkEnable),
        .mainClockCounterEnable(mainClockCounterEnable), .errClear(errClear), .errClearMask(errClearMask),
        .filterOverflow(filterOverflow), .filterUnderflow(filterUnderflow), .modBitValid(modBitValid),
        .modBit(modBit), .resultValid(resultValid), .rawResult(rawResult), .calBusy(calBusy),
        .calIsGain(calIsGain), .calDone(calDone), .calOffset(calOffset), .singleSeqBusy(singleSeqBusy),
        .errorFlags(errorFlags), .mainError(mainError), .convResult(convResult), .resultUpdate(resultUpdate),
        .offsetLoad(offsetLoad), .gainLoad(gainLoad), .mclkCount(mclkCount), .regWrite(regWrite),
        .readBlank(readBlank), .accessBlocked(accessBlocked));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic clr(input diag_bits_t m);
        errClearMask = m;
        errClear = 1'b1;
        tick(1);
        errClear = 1'b0;
        tick(2);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Every accepted write must match the oldest note; a stray one fails
    always @(negedge core_clk) begin
        if (regWrite.valid === 1'b1) begin
            wantWr = (expWr.size() > 0) ? expWr.pop_front() : '0;
            `CHECK("regWrite", wantWr, regWrite)
        end
    end
    initial begin
        #500000;
        miscompares++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        {resultValid, calBusy, calIsGain, calDone, singleSeqBusy, mainClockCounterEnable, errClear} = '0;
        {filterOverflow, filterUnderflow, modBitValid, modBit, rawResult, calOffset} = '0;
        analogCmp = '0;
        checkEnable = '1;
        errClearMask = '0;
        tick(5);
        rst = 1'b0;
        `CHECK("accessBlocked", 1'b1, accessBlocked)
        // Load delay is shorter than a frame, so a run blocks this write
        singleSeqBusy = 1'b1;
        host_u.frame(32, 32'h05123456);
        tick(6);
        `CHECK("ignored flag", 1'b1, errorFlags.ignoredWrite)
        singleSeqBusy = 1'b0;
        for (int i = 0; i < 200 && accessBlocked !== 1'b0; i++) tick(1);
        `CHECK("accessBlocked", 1'b0, accessBlocked)
        host_u.frame(32, 32'h05ABCDEF);
        tick(6);
        clr('0);
        `CHECK("kept flag", 1'b1, errorFlags.ignoredWrite)
        clr(9'h001);
        `CHECK("cleared flag", 1'b0, errorFlags.ignoredWrite)
        rnd = $random(seed);
        expWr.push_back({1'b1, 7'h05, rnd[23:0]});
        host_u.frame(32, {8'h05, rnd[23:0]});
        tick(6);
        host_u.frame(12, 32'h00000055);
        tick(6);
        `CHECK("count flag", 1'b1, errorFlags.sclkCount)
        host_u.frame(16, 32'h00003F00);
        tick(6);
        `CHECK("read-only flag", 1'b1, errorFlags.writeErr)
        clr(9'h002);
        host_u.frame(32, 32'h46000000);
        tick(6);
        `CHECK("write flag", 1'b1, errorFlags.writeErr)
        host_u.frame(16, 32'h0000C600);
        tick(6);
        `CHECK("read flag", 1'b1, errorFlags.readErr)
        `CHECK("readBlank", 1'b1, readBlank)
        `CHECK("mainError", 1'b1, mainError)
        clr('1);
        `CHECK("mainError", 1'b0, mainError)
        `CHECK("pending writes", 0, expWr.size())
        $display("test done: serial checks");
        singleSeqBusy = 1'b1;
        tick(3);
        `CHECK("accessBlocked", 1'b1, accessBlocked)
        singleSeqBusy = 1'b0;
        for (int k = 0; k < 4; k++) begin
            filterOverflow = (k == 0);
            filterUnderflow = (k == 1);
            tick(1);
            {filterOverflow, filterUnderflow} = 2'h0;
            for (int j = 0; j < 19 + k / 3; j++) begin
                {modBitValid, modBit} = {1'b1, k[0]};
                tick(1);
            end
            modBitValid = 1'b0;
            rawResult = $random(seed);
            resultValid = 1'b1;
            tick(1);
            resultValid = 1'b0;
            `CHECK("convResult", (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : rawResult, convResult)
            `CHECK("resultUpdate", 1'b1, resultUpdate)
            `CHECK("conversion flag", (k != 2), errorFlags.conversion)
            clr('1);
        end
        $display("test done: conversion");
        for (int k = 0; k < 6; k++) begin
            calBusy = 1'b1;
            calIsGain = (k > 3);
            calOffset = (k == 0) ? 16'h07FE : (k == 1) ? 16'h07FF : (k == 2) ? 16'hF7FF : 16'hF800;
            filterOverflow = (k == 5);
            tick(1);
            {filterOverflow, calDone} = 2'h1;
            tick(1);
            {calDone, calBusy} = 2'h0;
            `CHECK("coefficient load", (k == 1 || k == 2 || k == 4), calIsGain ? gainLoad : offsetLoad)
            tick(1);
            `CHECK("cal flag", (k == 0 || k == 3 || k == 5), errorFlags.conversion)
            clr('1);
        end
        $display("test done: calibration");
        for (int i = 0; i < 8; i++) begin
            checkEnable[4 + i / 2 + i / 6] = 1'b0;
            analogCmp = 8'h01 << i;
            tick(5);
            `CHECK("disabled flags", 9'h000, errorFlags)
            checkEnable = '1;
            tick(4);
            `CHECK("range flags", 9'h001 << (4 + i / 2 + i / 6), errorFlags)
            analogCmp = '0;
            tick(4);
            clr('1);
            `CHECK("cleared flags", 9'h000, errorFlags)
        end
        $display("test done: analog checks");
        mainClockCounterEnable = 1'b1;
        tick(131 * 3 + 4);
        `CHECK("mclkCount", 8'h03, mclkCount)
        $display("test done: clock counter");
        conclude();
    end
endmodule
